// ---- design/clk_gen_ctrl.v ----
// System clock prescaler, slow oscillator stop and stop-release wait control
`timescale 1ns/1ns
`include "clk_gen_defs.vh"

module clk_gen_ctrl #(
   parameter [17:0] WAIT_SEL0_CYC = `WAIT_SEL0_CYC,
   parameter [17:0] WAIT_SEL1_CYC = `WAIT_SEL1_CYC,
   parameter [17:0] WAIT_SEL2_CYC = `WAIT_SEL2_CYC,
   parameter [17:0] WAIT_SEL3_CYC = `WAIT_SEL3_CYC
) (
   input wire core_clk_i,
   input wire nrst_i,
   input wire [15:0] addr_i,
   input wire wr_byte_i,
   input wire wr_bit_i,
   input wire [2:0] bit_sel_i,
   input wire bit_val_i,
   input wire [7:0] wdata_i,
   input wire rd_i,
   input wire [1:0] src_sel_i,
   input wire soft_stop_ok_i,
   input wire [1:0] por_wait_sel_i,
   input wire stop_req_i,
   input wire stop_release_i,
   input wire osc_started_i,
   output reg [7:0] rdata_o,
   output reg sys_osc_en_o,
   output reg clk_ready_o,
   output reg cpu_clk_en_o,
   output reg periph_clk_en_o,
   output reg slow_osc_run_o,
   output reg wdt_src_fixed_o,
   output reg [1:0] src_sel_o
);

   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   localparam [4:0] ST_INIT = 5'h01;
   localparam [4:0] ST_START = 5'h02;
   localparam [4:0] ST_WAIT = 5'h04;
   localparam [4:0] ST_RUN = 5'h08;
   localparam [4:0] ST_STOP = 5'h10;

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Byte or single-bit write onto a register; only live bits change
   function [7:0] reg_write;
      input [7:0] old;
      input [7:0] live;
      input byte_wr;
      input [2:0] sel;
      input val;
      input [7:0] data;
      reg [7:0] merged;
      begin
         merged = old;
         if (byte_wr) begin
            merged = data;
         end else begin
            merged[sel] = val;
         end
         reg_write = merged & live;
      end
   endfunction

   // Wait length for a two-bit select code
   function [17:0] wait_len;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: wait_len = WAIT_SEL0_CYC;
            2'h1: wait_len = WAIT_SEL1_CYC;
            2'h2: wait_len = WAIT_SEL2_CYC;
            default: wait_len = WAIT_SEL3_CYC;
         endcase
      end
   endfunction

   // Mask of low divider bits that must all be one for one enable per ratio
   function [3:0] ratio_mask;
      input [2:0] log2_ratio;
      begin
         case (log2_ratio)
            3'd0: ratio_mask = 4'h0;
            3'd1: ratio_mask = 4'h1;
            3'd2: ratio_mask = 4'h3;
            3'd3: ratio_mask = 4'h7;
            default: ratio_mask = 4'hf;
         endcase
      end
   endfunction

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [7:0] cpu_divide_ctrl_q;
   reg [7:0] periph_divide_ctrl_q;
   reg [7:0] slow_osc_mode_q;
   reg [7:0] stop_wake_wait_sel_q;
   reg [4:0] state_q;
   reg [4:0] state_d;
   reg [17:0] wait_cnt_q;
   reg [17:0] wait_cnt_d;
   reg [3:0] div_cnt_q;
   reg [2:0] cpu_log2_q;
   reg [2:0] cpu_log2_d;
   reg [2:0] per_log2_q;
   reg [2:0] per_log2_d;
   reg [1:0] src_q;
   reg [1:0] por_sel_q;
   reg soft_stop_ok_q;
   reg straps_taken_q;

   wire cpu_div_bit;
   wire periph_div_hi;
   wire periph_div_lo;
   wire slow_osc_halt;
   wire [1:0] wait_sel;
   wire [3:0] cpu_mask;
   wire [3:0] per_mask;
   wire running;

   assign cpu_div_bit = cpu_divide_ctrl_q[`CPU_DIV_BIT_POS];
   assign periph_div_hi = periph_divide_ctrl_q[`PERIPH_DIV_HI_POS];
   assign periph_div_lo = periph_divide_ctrl_q[`PERIPH_DIV_LO_POS];
   assign slow_osc_halt = slow_osc_mode_q[`SLOW_OSC_HALT_POS];
   assign wait_sel = {stop_wake_wait_sel_q[`WAIT_SEL_HI_POS],
                      stop_wake_wait_sel_q[`WAIT_SEL_LO_POS]};
   assign cpu_mask = ratio_mask(cpu_log2_q);
   assign per_mask = ratio_mask(per_log2_q);
   assign running = (state_q == ST_RUN);

   // ****************************************************************
   // Option byte capture
   // ****************************************************************
   // Straps are sampled on the first edge after reset release, never by reset
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         src_q <= `SRC_INTERNAL;
         por_sel_q <= 2'h0;
         soft_stop_ok_q <= 1'b0;
         straps_taken_q <= 1'b0;
      end else if (!straps_taken_q) begin
         src_q <= src_sel_i;
         por_sel_q <= por_wait_sel_i;
         soft_stop_ok_q <= soft_stop_ok_i;
         straps_taken_q <= 1'b1;
      end
   end

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cpu_divide_ctrl_q <= `CPU_DIV_RESET;
         periph_divide_ctrl_q <= `PERIPH_DIV_RESET;
         slow_osc_mode_q <= `SLOW_OSC_MODE_RESET;
         // Content is meaningless until software writes it
         stop_wake_wait_sel_q <= `STOP_WAIT_SEL_RESET;
      end else if (wr_byte_i || wr_bit_i) begin
         if (addr_i == `CPU_DIV_ADDR) begin
            cpu_divide_ctrl_q <= reg_write(cpu_divide_ctrl_q, 8'h02, wr_byte_i,
                                           bit_sel_i, bit_val_i, wdata_i);
         end else if (addr_i == `PERIPH_DIV_ADDR) begin
            periph_divide_ctrl_q <= reg_write(periph_divide_ctrl_q, 8'h03, wr_byte_i,
                                              bit_sel_i, bit_val_i, wdata_i);
         end else if (addr_i == `SLOW_OSC_MODE_ADDR) begin
            slow_osc_mode_q <= reg_write(slow_osc_mode_q, 8'h01, wr_byte_i,
                                         bit_sel_i, bit_val_i, wdata_i);
         end else if (addr_i == `STOP_WAIT_SEL_ADDR && wr_byte_i) begin
            // Single-bit writes here are dropped
            stop_wake_wait_sel_q <= wdata_i & 8'h03;
         end
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   // Read data is registered and holds until the next read
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         if (addr_i == `CPU_DIV_ADDR) begin
            rdata_o <= cpu_divide_ctrl_q;
         end else if (addr_i == `PERIPH_DIV_ADDR) begin
            rdata_o <= periph_divide_ctrl_q;
         end else if (addr_i == `SLOW_OSC_MODE_ADDR) begin
            rdata_o <= slow_osc_mode_q;
         end else if (addr_i == `STOP_WAIT_SEL_ADDR) begin
            rdata_o <= stop_wake_wait_sel_q;
         end else begin
            rdata_o <= 8'h00;
         end
      end
   end

   // ****************************************************************
   // Division ratio decode
   // ****************************************************************
   // A prohibited setting keeps the last legal ratio so the clock never glitches
   always @* begin
      cpu_log2_d = cpu_log2_q;
      per_log2_d = per_log2_q;
      case ({periph_div_hi, periph_div_lo, cpu_div_bit})
         3'b000: cpu_log2_d = 3'd0;
         3'b010: cpu_log2_d = 3'd1;
         3'b001: cpu_log2_d = 3'd2;
         3'b100: cpu_log2_d = 3'd2;
         3'b011: cpu_log2_d = 3'd3;
         3'b101: cpu_log2_d = 3'd4;
         default: cpu_log2_d = cpu_log2_q;
      endcase
      case ({periph_div_hi, periph_div_lo})
         2'b00: per_log2_d = 3'd0;
         2'b01: per_log2_d = 3'd1;
         2'b10: per_log2_d = 3'd2;
         default: per_log2_d = per_log2_q;
      endcase
   end

   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cpu_log2_q <= 3'd2;
         per_log2_q <= 3'd2;
      end else begin
         cpu_log2_q <= cpu_log2_d;
         per_log2_q <= per_log2_d;
      end
   end

   // ****************************************************************
   // Prescaler
   // ****************************************************************
   // Divided clocks are issued as one-cycle enables of the system clock
   // Counter restarts at zero on entry to run so the first enables align
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_cnt_q <= 4'h0;
         cpu_clk_en_o <= 1'b0;
         periph_clk_en_o <= 1'b0;
      end else if (running) begin
         div_cnt_q <= div_cnt_q + 4'h1;
         cpu_clk_en_o <= ((div_cnt_q & cpu_mask) == cpu_mask);
         periph_clk_en_o <= ((div_cnt_q & per_mask) == per_mask);
      end else begin
         div_cnt_q <= 4'h0;
         cpu_clk_en_o <= 1'b0;
         periph_clk_en_o <= 1'b0;
      end
   end

   // ****************************************************************
   // Start, stop and stabilization sequencer
   // ****************************************************************
   always @* begin
      state_d = state_q;
      wait_cnt_d = wait_cnt_q;
      case (state_q)
         ST_INIT: begin
            if (straps_taken_q) begin
               state_d = ST_START;
            end
         end
         ST_START: begin
            // Counting begins only once oscillation is seen
            if (osc_started_i) begin
               if (src_q == `SRC_RESONATOR) begin
                  state_d = ST_WAIT;
                  // A zero count marks power-on; a stop-release preload is never
                  // zero while every wait length is above one cycle
                  if (straps_taken_q && wait_cnt_q == 18'h0) begin
                     wait_cnt_d = wait_len(por_sel_q) - 18'h1;
                  end
               end else begin
                  state_d = ST_RUN;
               end
            end
         end
         ST_WAIT: begin
            if (wait_cnt_q == 18'h0) begin
               state_d = ST_RUN;
            end else begin
               wait_cnt_d = wait_cnt_q - 18'h1;
            end
         end
         ST_RUN: begin
            if (stop_req_i) begin
               state_d = ST_STOP;
            end
         end
         ST_STOP: begin
            if (stop_release_i) begin
               state_d = ST_START;
               // Preloaded here so the start state knows it came from stop
               wait_cnt_d = wait_len(wait_sel) - 18'h1;
            end
         end
         default: begin
            state_d = ST_INIT;
         end
      endcase
   end

   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= ST_INIT;
         wait_cnt_q <= 18'h0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_START && osc_started_i && src_q != `SRC_RESONATOR) begin
            wait_cnt_q <= 18'h0;
         end else begin
            wait_cnt_q <= wait_cnt_d;
         end
      end
   end

   // ****************************************************************
   // Status and oscillator outputs
   // ****************************************************************
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sys_osc_en_o <= 1'b0;
         clk_ready_o <= 1'b0;
         slow_osc_run_o <= 1'b1;
         wdt_src_fixed_o <= 1'b1;
         src_sel_o <= `SRC_INTERNAL;
      end else begin
         sys_osc_en_o <= (state_d != ST_STOP) && (state_d != ST_INIT);
         clk_ready_o <= (state_d == ST_RUN);
         // Oscillator may only be halted when the option byte allows it
         slow_osc_run_o <= !(soft_stop_ok_q && slow_osc_halt);
         wdt_src_fixed_o <= !soft_stop_ok_q;
         src_sel_o <= src_q;
      end
   end

endmodule

// ---- dv/clk_gen_ctrl_asserts.sv ----
// Concurrent checks on the ports of the clock control block
`timescale 1ns/1ns
module clk_gen_ctrl_chk #(
   parameter [17:0] WAIT_SEL0_CYC = 18'h400
) (
   input wire core_clk_i,
   input wire nrst_i,
   input wire [15:0] addr_i,
   input wire wr_byte_i,
   input wire [7:0] wdata_i,
   input wire rd_i,
   input wire stop_req_i,
   input wire osc_started_i,
   input wire [7:0] rdata_o,
   input wire sys_osc_en_o,
   input wire clk_ready_o,
   input wire slow_osc_run_o,
   input wire wdt_src_fixed_o,
   input wire [1:0] src_sel_o
);
   // ****************************************************************
   // Helper logic
   // ****************************************************************
   // Cycles of running oscillation while clocks are still held
   logic [17:0] osc_cnt_q;
   logic mapped;
   assign mapped = addr_i inside {16'hff58, 16'hfff3, 16'hfff4, 16'hfffb};
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         osc_cnt_q <= 18'h0;
      end else if (clk_ready_o || !sys_osc_en_o || !osc_started_i) begin
         osc_cnt_q <= 18'h0;
      end else if (osc_cnt_q != 18'h3ffff) begin
         osc_cnt_q <= osc_cnt_q + 18'h1;
      end
   end
   default clocking dclk @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // ****************************************************************
   // Properties
   // ****************************************************************
   property p_wdt_fixed;
      wdt_src_fixed_o |-> slow_osc_run_o;
   endproperty
   a_wdt_fixed: assert property (p_wdt_fixed)
      else $error("slow oscillator stopped while watchdog source fixed");
   property p_halt;
      wr_byte_i && addr_i == 16'hff58 && wdata_i[0] && !wdt_src_fixed_o
         |-> ##[1:2] !slow_osc_run_o;
   endproperty
   a_halt: assert property (p_halt)
      else $error("slow oscillator did not stop");
   property p_run;
      wr_byte_i && addr_i == 16'hff58 && !wdata_i[0] |-> ##[1:2] slow_osc_run_o;
   endproperty
   a_run: assert property (p_run)
      else $error("slow oscillator did not run");
   property p_stop;
      clk_ready_o && stop_req_i |=> !clk_ready_o && !sys_osc_en_o;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop request did not halt clocks");
   property p_ready_osc;
      clk_ready_o |-> sys_osc_en_o;
   endproperty
   a_ready_osc: assert property (p_ready_osc)
      else $error("clocks ready with oscillator disabled");
   property p_no_early;
      src_sel_o == 2'h1 && !clk_ready_o && !osc_started_i |=> !clk_ready_o;
   endproperty
   a_no_early: assert property (p_no_early)
      else $error("clocks released before oscillation");
   property p_min_wait;
      $rose(clk_ready_o) && src_sel_o == 2'h1 |-> osc_cnt_q >= WAIT_SEL0_CYC;
   endproperty
   a_min_wait: assert property (p_min_wait)
      else $error("resonator wait too short");
   property p_no_wait;
      src_sel_o != 2'h1 && sys_osc_en_o && !clk_ready_o && osc_started_i
         |-> ##[1:3] clk_ready_o;
   endproperty
   a_no_wait: assert property (p_no_wait)
      else $error("wait applied to non-resonator source");
   property p_unmapped;
      rd_i && !mapped |=> rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_unused;
      rd_i && mapped |=> rdata_o[7:2] == 6'h00;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused bits read nonzero");
endmodule
bind clk_gen_ctrl clk_gen_ctrl_chk #(.WAIT_SEL0_CYC(WAIT_SEL0_CYC)) clk_gen_ctrl_chk_i (.*);

// ---- dv/clk_gen_ctrl_tb.sv ----
// Self-checking bench for the clock divider and oscillator control block
`timescale 1ns/1ns
module clk_gen_ctrl_tb;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic core_clk_i = 0, nrst_i = 0, wr_byte_i = 0, wr_bit_i = 0, bit_val_i = 0, rd_i = 0;
   logic soft_stop_ok_i = 0, stop_req_i = 0, stop_release_i = 0, osc_started_i = 1;
   logic [15:0] addr_i = 16'h0000;
   logic [2:0] bit_sel_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic [1:0] src_sel_i = 2'h0, por_wait_sel_i = 2'h3;
   logic [7:0] rdata_o, rd_q;
   logic sys_osc_en_o, clk_ready_o, cpu_clk_en_o, periph_clk_en_o, slow_osc_run_o;
   logic wdt_src_fixed_o;
   logic [1:0] src_sel_o;
   int failures = 0, samples_checked = 0, cyc = 0, n;
   // Short waits keep stop tests brief: 4, 8, 16, 32 cycles
   clk_gen_ctrl #(.WAIT_SEL0_CYC(18'h4), .WAIT_SEL1_CYC(18'h8), .WAIT_SEL2_CYC(18'h10),
      .WAIT_SEL3_CYC(18'h20)) clk_gen_ctrl_i (.*);
   initial forever #5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         test_done();
      end
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Byte write, or single-bit write of d[0] into bit s
   task automatic wr(logic [15:0] a, logic [7:0] d, logic bw = 0, logic [2:0] s = 3'h0);
      @(negedge core_clk_i);
      addr_i = a;
      wdata_i = d;
      bit_val_i = d[0];
      bit_sel_i = s;
      wr_byte_i = !bw;
      wr_bit_i = bw;
      @(negedge core_clk_i);
      wr_byte_i = 0;
      wr_bit_i = 0;
   endtask
   task automatic rdchk(string name, logic [15:0] a, logic [7:0] exp);
      @(negedge core_clk_i);
      addr_i = a;
      rd_i = 1;
      @(negedge core_clk_i);
      rd_i = 0;
      check(name, rdata_o, exp);
   endtask
   task automatic waitrdy();
      n = 0;
      while (clk_ready_o !== 1'b1 && n < 300) begin
         @(negedge core_clk_i);
         n++;
      end
   endtask
   task automatic boot(logic [1:0] src, logic ok, logic [1:0] por = 2'h3);
      @(negedge core_clk_i);
      nrst_i = 0;
      src_sel_i = src;
      soft_stop_ok_i = ok;
      por_wait_sel_i = por;
      osc_started_i = 1;
      repeat (3) @(negedge core_clk_i);
      nrst_i = 1;
      waitrdy();
      check("source", src_sel_o, src);
      // Straps taken at edge 1, start at edge 2, oscillation seen at edge 3
      check("boot wait", 8'(n), (src == 2'h1) ? 8'(3 + (4 << por)) : 8'h03);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs();
      rdchk("cpu reset", 16'hfffb, 8'h02);
      rdchk("periph reset", 16'hfff3, 8'h02);
      rdchk("slow reset", 16'hff58, 8'h00);
      wr(16'hfff4, 8'hff);
      rdchk("wait unused", 16'hfff4, 8'h03);
      wr(16'hfff4, 8'h00, 1, 3'h0);
      rdchk("wait bit write", 16'hfff4, 8'h03);
      wr(16'hff58, 8'hff);
      rdchk("slow unused", 16'hff58, 8'h01);
      wr(16'hff58, 8'h00, 1, 3'h0);
      rdchk("slow bit write", 16'hff58, 8'h00);
      wr(16'hfffb, 8'hff);
      rdchk("cpu unused", 16'hfffb, 8'h02);
      wr(16'hfffb, 8'h00, 1, 3'h1);
      rdchk("cpu bit write", 16'hfffb, 8'h00);
      wr(16'hfff3, 8'hff);
      wr(16'hfff3, 8'h01, 1, 3'h7);
      rdchk("periph unused", 16'hfff3, 8'h03);
      rdchk("unmapped", 16'hfff5, 8'h00);
   endtask
   task automatic t_ratio();
      logic [2:0] code [7] = '{3'b000, 3'b010, 3'b001, 3'b100, 3'b011, 3'b101, 3'b110};
      int cr [7] = '{1, 2, 4, 4, 8, 16, 16};
      int pr [7] = '{1, 2, 1, 4, 2, 4, 4};
      logic [7:0] cc, pc;
      for (int i = 0; i < 7; i++) begin
         wr(16'hfff3, {6'h0, code[i][2:1]});
         wr(16'hfffb, {6'h0, code[i][0], 1'b0});
         repeat (4) @(negedge core_clk_i);
         cc = 0;
         pc = 0;
         repeat (32) begin
            @(negedge core_clk_i);
            cc += cpu_clk_en_o;
            pc += periph_clk_en_o;
         end
         check("cpu ratio", cc, 8'(32 / cr[i]));
         check("periph ratio", pc, 8'(32 / pr[i]));
      end
   endtask
   task automatic t_stop(logic [1:0] sel, int exp);
      wr(16'hfff4, {6'h0, sel});
      @(negedge core_clk_i);
      stop_req_i = 1;
      @(negedge core_clk_i);
      stop_req_i = 0;
      osc_started_i = 0;
      check("stopped", {clk_ready_o, sys_osc_en_o}, 8'h0);
      @(negedge core_clk_i);
      stop_release_i = 1;
      @(negedge core_clk_i);
      stop_release_i = 0;
      repeat (6) @(negedge core_clk_i);
      check("no oscillation", {clk_ready_o, sys_osc_en_o}, 8'h1);
      osc_started_i = 1;
      waitrdy();
      check("stop wait", 8'(n), 8'(exp));
   endtask
   task automatic t_slow(logic ok);
      wr(16'hff58, 8'h01);
      repeat (3) @(negedge core_clk_i);
      check("slow halted", slow_osc_run_o, !ok);
      check("watchdog fixed", wdt_src_fixed_o, !ok);
      wr(16'hff58, 8'h00);
      repeat (3) @(negedge core_clk_i);
      check("slow running", slow_osc_run_o, 8'h1);
   endtask
   initial begin
      boot(2'h0, 1'b0);
      t_regs();
      t_ratio();
      t_slow(1'b0);
      t_stop(2'h3, 1);
      boot(2'h2, 1'b1);
      t_slow(1'b1);
      t_stop(2'h2, 1);
      boot(2'h1, 1'b0, 2'h0);
      boot(2'h1, 1'b1);
      for (int s = 0; s < 4; s++) begin
         t_stop(s[1:0], (4 << s) + 1);
      end
      test_done();
   end
endmodule

// ---- inc/clk_gen_defs.vh ----
// Constants for the system clock divider and oscillator control block
//
// Behaviour
// - Reset loads CPU and peripheral divide with 02h
// - CPU clock ratio from three divide bits
// - Peripheral divide 01h gives sys_clk/2 peripheral
// - Peripheral divide 02h gives sys_clk/4 peripheral
// - Option byte selects one of three sources
// - Reset clears slow oscillator mode to 00h
// - Halt bit stops slow oscillator when permitted
// - Forbidden stop ignores halt, watchdog source fixed
// - Stop-release wait only for resonator after stop
// - Internal or external source: no stop wait
// - Wait select gives 2^10/12/15/17 periods
// - Wait select written by whole bytes only
// - Wait counts from oscillation start, not release
// - Power-on wait comes from option byte
// - Bit and byte writes accepted on three registers
`ifndef CLK_GEN_DEFS_VH
`define CLK_GEN_DEFS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define SLOW_OSC_MODE_ADDR 16'hff58
`define PERIPH_DIV_ADDR 16'hfff3
`define STOP_WAIT_SEL_ADDR 16'hfff4
`define CPU_DIV_ADDR 16'hfffb

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CPU_DIV_BIT_POS 1
`define PERIPH_DIV_LO_POS 0
`define PERIPH_DIV_HI_POS 1
`define SLOW_OSC_HALT_POS 0
`define WAIT_SEL_LO_POS 0
`define WAIT_SEL_HI_POS 1
`define CPU_DIV_RESET 8'h02
`define PERIPH_DIV_RESET 8'h02
`define SLOW_OSC_MODE_RESET 8'h00
`define STOP_WAIT_SEL_RESET 8'h00

// ****************************************************************
// Clock source codes from the option byte
// ****************************************************************
`define SRC_INTERNAL 2'h0
`define SRC_RESONATOR 2'h1
`define SRC_EXTERNAL 2'h2

// ****************************************************************
// Timing: waits in sys_clk periods, core cycles per sys_clk period
// ****************************************************************
`define CORE_PER_SYS_CLK 18'd1
`define WAIT_SEL0_PERIODS 18'd1024
`define WAIT_SEL1_PERIODS 18'd4096
`define WAIT_SEL2_PERIODS 18'd32768
`define WAIT_SEL3_PERIODS 18'd131072
`define WAIT_SEL0_CYC (`WAIT_SEL0_PERIODS * `CORE_PER_SYS_CLK)
`define WAIT_SEL1_CYC (`WAIT_SEL1_PERIODS * `CORE_PER_SYS_CLK)
`define WAIT_SEL2_CYC (`WAIT_SEL2_PERIODS * `CORE_PER_SYS_CLK)
`define WAIT_SEL3_CYC (`WAIT_SEL3_PERIODS * `CORE_PER_SYS_CLK)

`endif
